// *** flash_read_pkg.sv ***
// constants shared by the continuous array read command block
`default_nettype none
package flash_read_pkg;
    localparam logic [7:0] OP_READ_LEGACY = 8'he8;
    localparam logic [7:0] OP_READ_FAST2  = 8'h1b;
    localparam logic [7:0] OP_READ_FAST1  = 8'h0b;
    localparam logic [7:0] OP_READ_SLOW   = 8'h03;
    localparam logic [2:0] DUMMY_LEGACY   = 3'h4;
    localparam logic [2:0] DUMMY_FAST2    = 3'h2;
    localparam logic [2:0] DUMMY_FAST1    = 3'h1;
    localparam logic [2:0] DUMMY_SLOW     = 3'h0;
    localparam int         PAGE_BITS      = 13;
    localparam int         BYTE_BITS      = 10;
    localparam int         LOC_BITS       = PAGE_BITS + BYTE_BITS;
    localparam int         ADDR_BITS      = 24;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    // 512 mode: 9 byte bits, so the page field starts at address bit 9
    localparam int         BIN_BYTE_BITS  = 9;
    localparam logic [9:0] LAST_BYTE_528  = 10'h20f;
    localparam logic [9:0] LAST_BYTE_512  = 10'h1ff;
    localparam int         FIFO_WIDTH     = 8;
    localparam int         FIFO_DEPTH     = 32;
    localparam logic [7:0] UNDERRUN_BYTE  = 8'hff;
    localparam int         CLK_PERIOD_NS  = 10;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR   = 3'b001,
        ST_DUMMY  = 3'b010,
        ST_DATA   = 3'b011,
        ST_IGNORE = 3'b100
    } rd_state_e;
endpackage
`default_nettype wire

// *** pin_sampler.sv ***
// registers the serial pins and derives serial clock edge pulses
`default_nettype none
module pin_sampler (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic selN,
    input  wire logic serClk,
    input  wire logic serIn,
    output logic      selQ,
    output logic      sclkRise,
    output logic      sclkFall,
    output logic      siQ
);
    logic selReg;
    logic clkReg;
    logic clkPrevReg;
    logic siReg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            selReg     <= 1'b1;
            clkReg     <= 1'b0;
            clkPrevReg <= 1'b0;
            siReg      <= 1'b0;
        end else begin
            selReg     <= selN;
            clkReg     <= serClk;
            clkPrevReg <= clkReg;
            siReg      <= serIn;
        end
    end

    // selQ high means deselected
    assign selQ     = selReg;
    assign sclkRise = clkReg & ~clkPrevReg;
    assign sclkFall = ~clkReg & clkPrevReg;
    assign siQ      = siReg;
endmodule
`default_nettype wire

// *** byte_fifo.sv ***
// flip-flop fifo with valid/ready on both sides and a flush
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] memReg [DEPTH];
    logic [PW-1:0]    wrReg;
    logic [PW-1:0]    wrNext;
    logic [PW-1:0]    rdReg;
    logic [PW-1:0]    rdNext;
    logic [PW:0]      cntReg;
    logic [PW:0]      cntNext;
    logic             doPush;
    logic             doPop;

    assign inReady  = (cntReg != (PW+1)'(DEPTH));
    assign outValid = (cntReg != '0);
    assign outData  = memReg[rdReg];
    assign doPush   = inValid && inReady && !flush;
    assign doPop    = outReady && outValid && !flush;

    always_comb begin
        wrNext  = wrReg;
        rdNext  = rdReg;
        cntNext = cntReg;
        if (flush) begin
            wrNext  = '0;
            rdNext  = '0;
            cntNext = '0;
        end else begin
            if (doPush) begin
                wrNext = (wrReg == PW'(DEPTH - 1)) ? '0 : wrReg + PW'(1);
            end
            if (doPop) begin
                rdNext = (rdReg == PW'(DEPTH - 1)) ? '0 : rdReg + PW'(1);
            end
            cntNext = cntReg + (PW+1)'(doPush) - (PW+1)'(doPop);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrReg  <= '0;
            rdReg  <= '0;
            cntReg <= '0;
        end else begin
            wrReg  <= wrNext;
            rdReg  <= rdNext;
            cntReg <= cntNext;
        end
    end

    // storage needs no reset; only the pointers define what is valid
    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            memReg[wrReg] <= inData;
        end
    end
endmodule
`default_nettype wire

// *** flash_array_read.sv ***
// serial command decoder and streamer for continuous main-array reads
`default_nettype none
// How it works
// - E8h: three address bytes, four dummy bytes
// - 528 mode: 13 page bits, 10 byte bits
// - 512 mode: 22-bit address, 13 page, 9 byte
// - internal address counter advances, no readdressing
// - after header, one data bit per clock
// - last byte of page continues into next page
// - end of array wraps to first page
// - select rising ends read, output goes tristate
// - array reads never touch the buffers
// - 1Bh: three address bytes, two dummy bytes
// - 0Bh: three address bytes, one dummy byte
// - 03h: data right after third address byte
// - serial clock may idle low or high
// - command starts at select fall, opcode first
// - everything travels most significant bit first
module flash_array_read
    import flash_read_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire logic                      selN,
    input  wire logic                      serClk,
    input  wire logic                      serIn,
    output logic                           serOut,
    output logic                           serOutEn,
    input  wire logic                      pageBinary,
    output logic                           memReq,
    output logic [flash_read_pkg::PAGE_BITS-1:0] memPage,
    output logic [flash_read_pkg::BYTE_BITS-1:0] memByte,
    input  wire logic                      memRdValid,
    input  wire logic [flash_read_pkg::FIFO_WIDTH-1:0] memRdData
);
    import flash_read_pkg::*;

    function automatic logic [LOC_BITS-1:0] locFrom(input logic [ADDR_BITS-1:0] a, input logic bin);
        if (bin) begin
            return {a[BIN_BYTE_BITS+PAGE_BITS-1:BIN_BYTE_BITS], 1'b0, a[BIN_BYTE_BITS-1:0]};
        end
        return a[LOC_BITS-1:0];
    endfunction

    function automatic logic [LOC_BITS-1:0] locNext(input logic [LOC_BITS-1:0] loc, input logic bin);
        logic [BYTE_BITS-1:0] last;
        last = bin ? LAST_BYTE_512 : LAST_BYTE_528;
        if (loc[BYTE_BITS-1:0] >= last) begin
            // page counter overflows to zero at the array end
            return {loc[LOC_BITS-1:BYTE_BITS] + PAGE_BITS'(1), BYTE_BITS'(0)};
        end
        return {loc[LOC_BITS-1:BYTE_BITS], loc[BYTE_BITS-1:0] + BYTE_BITS'(1)};
    endfunction

    logic                  selQ;
    logic                  sclkRise;
    logic                  sclkFall;
    logic                  siQ;
    rd_state_e             stateReg, stateNext;
    logic [2:0]            bitCntReg, bitCntNext;
    logic [1:0]            byteCntReg, byteCntNext;
    logic [2:0]            dummyLeftReg, dummyLeftNext;
    logic [ADDR_BITS-1:0]  shiftInReg, shiftInNext;
    logic [ADDR_BITS-1:0]  sinNext;
    logic [7:0]            outShiftReg, outShiftNext;
    logic                  serOutReg, serOutNext;
    logic                  serOutEnReg, serOutEnNext;
    logic                  startFetch;
    logic                  fifoPop;
    logic [7:0]            loadByte;
    logic [LOC_BITS-1:0]   locReg, locNext_q;
    logic                  binReg, binNext;
    logic                  fetchOnReg, fetchOnNext;
    logic                  memReqReg, memReqNext;
    logic                  discardReg, discardNext;
    logic                  fifoPush;
    logic                  fifoInReady;
    logic                  fifoOutValid;
    logic [FIFO_WIDTH-1:0] fifoOutData;

    pin_sampler u_pins (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .selN     (selN),
        .serClk   (serClk),
        .serIn    (serIn),
        .selQ     (selQ),
        .sclkRise (sclkRise),
        .sclkFall (sclkFall),
        .siQ      (siQ)
    );

    // prefetched array bytes; keeps the stream gapless while the array is slow
    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .flush    (selQ),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (memRdData),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    assign sinNext  = {shiftInReg[ADDR_BITS-2:0], siQ};
    assign loadByte = fifoOutValid ? fifoOutData : UNDERRUN_BYTE;

    // command header and serial output
    always_comb begin
        stateNext     = stateReg;
        bitCntNext    = bitCntReg;
        byteCntNext   = byteCntReg;
        dummyLeftNext = dummyLeftReg;
        shiftInNext   = shiftInReg;
        outShiftNext  = outShiftReg;
        serOutNext    = serOutReg;
        serOutEnNext  = serOutEnReg;
        startFetch    = 1'b0;
        fifoPop       = 1'b0;
        if (selQ) begin
            // deselect aborts whatever the host left unfinished
            stateNext    = ST_OPCODE;
            bitCntNext   = '0;
            byteCntNext  = '0;
            serOutEnNext = 1'b0;
            serOutNext   = 1'b0;
        end else if (sclkRise) begin
            // data in on rising edges only, so idle level does not matter
            shiftInNext = sinNext;
            bitCntNext  = bitCntReg + 3'd1;
            unique case (stateReg)
                ST_OPCODE: begin
                    if (bitCntReg == BIT_LAST) begin
                        stateNext = ST_ADDR;
                        unique case (sinNext[7:0])
                            OP_READ_LEGACY: dummyLeftNext = DUMMY_LEGACY;
                            OP_READ_FAST2:  dummyLeftNext = DUMMY_FAST2;
                            OP_READ_FAST1:  dummyLeftNext = DUMMY_FAST1;
                            OP_READ_SLOW:   dummyLeftNext = DUMMY_SLOW;
                            default:        stateNext = ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (bitCntReg == BIT_LAST) begin
                        byteCntNext = byteCntReg + 2'd1;
                        if (byteCntReg == ADDR_LAST_BYTE) begin
                            startFetch = 1'b1;
                            stateNext  = (dummyLeftReg == 3'd0) ? ST_DATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (bitCntReg == BIT_LAST) begin
                        dummyLeftNext = dummyLeftReg - 3'd1;
                        if (dummyLeftReg == 3'd1) begin
                            stateNext = ST_DATA;
                        end
                    end
                end
                ST_DATA, ST_IGNORE: begin
                end
                default: stateNext = ST_IGNORE;
            endcase
        end else if (sclkFall && stateReg == ST_DATA) begin
            serOutEnNext = 1'b1;
            if (bitCntReg == 3'd0) begin
                fifoPop      = fifoOutValid;
                serOutNext   = loadByte[7];
                outShiftNext = {loadByte[6:0], 1'b0};
            end else begin
                serOutNext   = outShiftReg[7];
                outShiftNext = {outShiftReg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stateReg     <= ST_OPCODE;
            bitCntReg    <= '0;
            byteCntReg   <= '0;
            dummyLeftReg <= '0;
            shiftInReg   <= '0;
            outShiftReg  <= '0;
            serOutReg    <= 1'b0;
            serOutEnReg  <= 1'b0;
        end else begin
            stateReg     <= stateNext;
            bitCntReg    <= bitCntNext;
            byteCntReg   <= byteCntNext;
            dummyLeftReg <= dummyLeftNext;
            shiftInReg   <= shiftInNext;
            outShiftReg  <= outShiftNext;
            serOutReg    <= serOutNext;
            serOutEnReg  <= serOutEnNext;
        end
    end

    // array prefetch; read-only port, the data buffers are never written
    assign fifoPush = memRdValid && memReqReg && !discardReg;

    always_comb begin
        locNext_q   = locReg;
        binNext     = binReg;
        fetchOnNext = fetchOnReg;
        memReqNext  = memReqReg;
        discardNext = discardReg;
        if (memRdValid && memReqReg) begin
            memReqNext  = 1'b0;
            discardNext = 1'b0;
            if (!discardReg) begin
                locNext_q = locNext(locReg, binReg);
            end
        end
        if (selQ) begin
            fetchOnNext = 1'b0;
            // a request in flight cannot be withdrawn, so its answer is dropped
            if (memReqReg && !memRdValid) begin
                discardNext = 1'b1;
            end
        end else if (startFetch) begin
            locNext_q   = locFrom(sinNext, pageBinary);
            binNext     = pageBinary;
            fetchOnNext = 1'b1;
        end else if (fetchOnReg && !memReqReg && fifoInReady) begin
            memReqNext = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            locReg     <= '0;
            binReg     <= 1'b0;
            fetchOnReg <= 1'b0;
            memReqReg  <= 1'b0;
            discardReg <= 1'b0;
        end else begin
            locReg     <= locNext_q;
            binReg     <= binNext;
            fetchOnReg <= fetchOnNext;
            memReqReg  <= memReqNext;
            discardReg <= discardNext;
        end
    end

    assign serOut   = serOutReg;
    assign serOutEn = serOutEnReg;
    assign memReq   = memReqReg;
    assign memPage  = locReg[LOC_BITS-1:BYTE_BITS];
    assign memByte  = locReg[BYTE_BITS-1:0];

    // checks
    logic [PAGE_BITS-1:0] pg528;
    logic [PAGE_BITS-1:0] pg512;
    logic [PAGE_BITS-1:0] curPage;
    logic [BYTE_BITS-1:0] lastByte;
    logic                 headerBit;
    logic                 lastRise;
    assign pg528     = sinNext[LOC_BITS-1:BYTE_BITS];
    assign pg512     = sinNext[BIN_BYTE_BITS+PAGE_BITS-1:BIN_BYTE_BITS];
    assign curPage   = locReg[LOC_BITS-1:BYTE_BITS];
    assign lastByte  = binReg ? LAST_BYTE_512 : LAST_BYTE_528;
    assign headerBit = fifoOutData[7];
    assign lastRise  = !selQ && sclkRise && bitCntReg == BIT_LAST;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence sOpcodeEnd(logic [7:0] op);
        stateReg == ST_OPCODE && lastRise && sinNext[7:0] == op;
    endsequence
    sequence sDataFall;
        !selQ && sclkFall && stateReg == ST_DATA;
    endsequence
    sequence sAdvance;
        memRdValid && memReqReg && !discardReg && locReg[BYTE_BITS-1:0] == lastByte;
    endsequence

    a_deselect_tristate: assert property (selQ |=> !serOutEnReg && stateReg == ST_OPCODE)
        else $error("output still driven after deselect");
    a_legacy_dummy: assert property (sOpcodeEnd(OP_READ_LEGACY) |=> stateReg == ST_ADDR && dummyLeftReg == 3'd4)
        else $error("legacy read dummy count wrong");
    a_fast2_dummy: assert property (sOpcodeEnd(OP_READ_FAST2) |=> stateReg == ST_ADDR && dummyLeftReg == 3'd2)
        else $error("fast read dummy count not two");
    a_fast1_dummy: assert property (sOpcodeEnd(OP_READ_FAST1) |=> dummyLeftReg == 3'd1)
        else $error("fast read dummy count not one");
    a_slow_nodummy: assert property (stateReg == ST_ADDR && lastRise && byteCntReg == ADDR_LAST_BYTE
            && dummyLeftReg == 3'd0 |=> stateReg == ST_DATA)
        else $error("slow read did not enter data phase");
    a_load_528: assert property (startFetch && !pageBinary |=> curPage == $past(pg528))
        else $error("528 page number decoded wrong");
    a_load_512: assert property (startFetch && pageBinary |=> curPage == $past(pg512) && !locReg[BIN_BYTE_BITS])
        else $error("512 page number decoded wrong");
    a_page_cross: assert property ((sAdvance and (curPage != '1))
            |=> memByte == '0 && curPage == $past(curPage) + 13'd1)
        else $error("page crossover did not move to next page");
    a_array_wrap: assert property ((sAdvance and (curPage == '1)) |=> locReg == '0)
        else $error("array end did not wrap to first page");
    a_msb_first: assert property (sDataFall ##0 bitCntReg == 3'd0 && fifoOutValid |=> serOutReg == $past(headerBit))
        else $error("byte not sent msb first");
    a_data_drive: assert property (sDataFall |=> serOutEnReg [*1] ##1 (serOutEnReg || $past(selQ)))
        else $error("data bit not driven after header");
endmodule
`default_nettype wire

// *** array_mem_model.sv ***
// behavioural main-array model answering the block's read requests
`default_nettype none
module array_mem_model
    import flash_read_pkg::*;
(
    input  wire logic                                    ref_clk,
    input  wire logic                                    arst_n,
    input  wire logic                                    memReq,
    input  wire logic [flash_read_pkg::PAGE_BITS-1:0]    memPage,
    input  wire logic [flash_read_pkg::BYTE_BITS-1:0]    memByte,
    output logic                                         memRdValid,
    output logic      [flash_read_pkg::FIFO_WIDTH-1:0]   memRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] waitCnt;
    logic       busy;

    function automatic logic [7:0] cellOf(input logic [12:0] p, input logic [9:0] b);
        logic [15:0] sum;
        sum = {3'b000, p} * 16'd29 + {6'b000000, b};
        return sum[7:0];
    endfunction

    // latency varies 1..4 cycles so both prompt and slow answers occur
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            memRdValid <= 1'b0;
            memRdData  <= 8'h00;
            busy       <= 1'b0;
            waitCnt    <= 2'h0;
        end else begin
            memRdValid <= 1'b0;
            // data lines carry noise outside the answer cycle
            memRdData  <= 8'($urandom);
            if (memRdValid) begin
                busy <= 1'b1;
            end else if (busy) begin
                if (!memReq) begin
                    busy <= 1'b0;
                end
            end else if (memReq) begin
                if (waitCnt == 2'h0) begin
                    memRdValid <= 1'b1;
                    memRdData  <= cellOf(memPage, memByte);
                    waitCnt    <= 2'($urandom_range(3, 0));
                end else begin
                    waitCnt <= waitCnt - 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** serial_flash_array_read_test.sv ***
// self-checking bench for the continuous array read block
`default_nettype none
module serial_flash_array_read_test;
    import flash_read_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 10;

    logic        ref_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        selN    = 1'b1;
    logic        serClk  = 1'b0;
    logic        serIn   = 1'b0;
    logic        pageBinary = 1'b0;
    logic        serOut;
    logic        serOutEn;
    logic        memReq;
    logic [12:0] memPage;
    logic [9:0]  memByte;
    logic        memRdValid;
    logic [7:0]  memRdData;
    int          n_fail = 0;
    int          total_checks = 0;
    logic [7:0]  expQ[$];
    logic [7:0]  shiftByte = 8'h00;
    int          bitCnt = 0;
    logic        prevClk = 1'b0;
    logic        sawEn = 1'b0;
    logic [7:0]  opTab[4]  = '{OP_READ_LEGACY, OP_READ_FAST2, OP_READ_FAST1, OP_READ_SLOW};
    logic [2:0]  dumTab[4] = '{DUMMY_LEGACY, DUMMY_FAST2, DUMMY_FAST1, DUMMY_SLOW};

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    flash_array_read uut (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .selN       (selN),
        .serClk     (serClk),
        .serIn      (serIn),
        .serOut     (serOut),
        .serOutEn   (serOutEn),
        .pageBinary (pageBinary),
        .memReq     (memReq),
        .memPage    (memPage),
        .memByte    (memByte),
        .memRdValid (memRdValid),
        .memRdData  (memRdData)
    );

    array_mem_model arrayMem (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .memReq     (memReq),
        .memPage    (memPage),
        .memByte    (memByte),
        .memRdValid (memRdValid),
        .memRdData  (memRdData)
    );

    function automatic logic [7:0] cellOf(input logic [12:0] p, input logic [9:0] b);
        logic [15:0] sum;
        sum = {3'b000, p} * 16'd29 + {6'b000000, b};
        return sum[7:0];
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // monitor: host samples the output on serial clock rises
    always @(posedge ref_clk) begin
        if (serOutEn === 1'b1) begin
            sawEn = 1'b1;
        end
        if (serOutEn !== 1'b1) begin
            bitCnt = 0;
        end else if (serClk === 1'b1 && prevClk === 1'b0) begin
            shiftByte = {shiftByte[6:0], serOut};
            bitCnt++;
            if (bitCnt == 8) begin
                bitCnt = 0;
                if (expQ.size() == 0) begin
                    check("unexpected byte", shiftByte, 8'hxx);
                end else begin
                    check("data byte", shiftByte, expQ.pop_front());
                end
            end
        end
        prevClk = serClk;
    end

    // one command; cut >= 0 aborts after that many header bits
    task automatic run_cmd(input string tname, input logic [7:0] op, input int nDummy, input logic bin,
                           input logic [12:0] page, input logic [9:0] byteIdx, input int nBytes,
                           input logic mode3, input int cut, input logic known);
        logic [63:0] hdr;
        logic [23:0] addr;
        logic [12:0] p;
        logic [9:0]  b;
        int          nHdr;
        int          i;
        addr = bin ? {2'b00, page, byteIdx[8:0]} : {1'b0, page, byteIdx};
        hdr  = {op, addr, 32'($urandom)};
        nHdr = 32 + 8 * nDummy;
        p = page;
        b = byteIdx;
        for (i = 0; i < nBytes && known && cut < 0; i++) begin
            expQ.push_back(cellOf(p, b));
            if (b >= (bin ? 10'd511 : 10'd527)) begin
                b = 10'd0;
                p = p + 13'd1;
            end else begin
                b = b + 10'd1;
            end
        end
        tick(1);
        serClk     <= mode3;
        pageBinary <= bin;
        sawEn = 1'b0;
        tick(3);
        selN <= 1'b0;
        tick(2);
        // select stays low through header and data
        for (i = 0; i < nHdr && i != cut; i++) begin
            serClk <= 1'b0;
            serIn  <= hdr[63-i];
            tick(HALF);
            serClk <= 1'b1;
            tick(HALF);
        end
        for (i = 0; i < nBytes * 8 && cut < 0; i++) begin
            serClk <= 1'b0;
            serIn  <= 1'($urandom);
            tick(HALF);
            serClk <= 1'b1;
            tick(HALF);
        end
        if (!mode3) begin
            serClk <= 1'b0;
            tick(HALF);
        end
        selN <= 1'b1;
        tick(1);
        for (i = 0; i < 6 && serOutEn !== 1'b0; i++) begin
            tick(1);
        end
        check("enable after deselect", {7'h00, serOutEn}, 8'h00);
        check("bytes left over", 8'(expQ.size()), 8'h00);
        if (!known) begin
            check("enable on unknown opcode", {7'h00, sawEn}, 8'h00);
        end
        expQ.delete();
        tick(4);
        $display("test %s done", tname);
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        $display("MISMATCH watchdog expected finish seen timeout");
        report_and_stop();
    end

    initial begin
        int k;
        int t;
        void'($urandom(58346));
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        tick(3);
        run_cmd("slow 528 page cross", OP_READ_SLOW, int'(DUMMY_SLOW), 1'b0, 13'd5, 10'd526, 4, 1'b0, -1, 1'b1);
        run_cmd("fast1 512 array wrap", OP_READ_FAST1, int'(DUMMY_FAST1), 1'b1, 13'h1fff, 10'd510, 4, 1'b1, -1,
                1'b1);
        run_cmd("fast2 528 array wrap", OP_READ_FAST2, int'(DUMMY_FAST2), 1'b0, 13'h1fff, 10'd527, 3, 1'b0, -1,
                1'b1);
        run_cmd("legacy 512", OP_READ_LEGACY, int'(DUMMY_LEGACY), 1'b1, 13'd100, 10'd511, 3, 1'b1, -1, 1'b1);
        run_cmd("unknown opcode", 8'h5a, 0, 1'b0, 13'd0, 10'd0, 2, 1'b0, -1, 1'b0);
        run_cmd("abort in address", OP_READ_SLOW, 0, 1'b0, 13'd7, 10'd3, 2, 1'b1, 20, 1'b1);
        run_cmd("after abort", OP_READ_SLOW, 0, 1'b0, 13'd7, 10'd3, 2, 1'b1, -1, 1'b1);
        // six random commands, each with a random opcode, clock mode and page size
        for (k = 0; k < 6; k++) begin
            t = $urandom_range(3, 0);
            run_cmd("random", opTab[t], int'(dumTab[t]), 1'($urandom), 13'($urandom),
                    10'($urandom_range(511, 0)), 3, 1'($urandom), -1, 1'b1);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
